// ### prls_pcs_rx_lane_status.sv
// receive lane status reporting with apb registers and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "prls_defines.svh"
module prls_pcs_rx_lane_status
	import prls_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// raw lane events from the receive datapath
	input wire logic rx_word_valid,
	input wire prls_lanes_t lane_lock_in,
	input wire prls_lanes_t marker_strobe,
	input wire prls_lanes_t marker_malformed,
	input wire logic [39:0] framing_err_in,
	input wire prls_lanes_t framing_err_valid_in,
	// all-lane conditions
	input wire logic deskew_done_in,
	input wire logic align_fault_in,
	input wire logic high_error_rate_state,
	input wire logic internal_fault_in,
	input wire logic received_local_fault,
	// status outputs
	output logic [39:0] framing_err,
	output prls_lanes_t framing_err_valid,
	output prls_lanes_t lane_block_lock,
	output prls_lanes_t lane_word_sync,
	output prls_lanes_t lane_word_sync_loss,
	output prls_lanes_t marker_interval_error,
	output prls_lanes_t marker_repeat_error,
	output prls_lanes_t marker_word_error,
	output logic lanes_aligned,
	output logic coding_status,
	output logic local_fault,
	output logic aligned_error
);
	// all checks below share the one clock and the bus reset
	default clocking ast_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////
	function automatic prls_count_t count_step(input prls_count_t c);
		count_step = (c == '1) ? c : prls_count_t'(c + 17'h00001);
	endfunction

	logic [15:0] spacing_q;
	prls_events_t int_stat_q, int_mask_q;
	logic run_q;
	prls_lanes_t seen_q, lost_q, lock_prev_q, interval_q, repeat_q;
	prls_lanes_t wsync_q, loss_q, mkerr_q, lock_q, fev_q;
	logic [39:0] fe_q;
	logic aligned_q, status_q, lf_q, aerr_q, align_prev_q, align_lost_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, irq_q;
	prls_count_t cnt_q [`PRLS_LANES];
	logic [2:0] rep_cnt_q [`PRLS_LANES];

	wire prls_count_t spacing_target = {1'b0, spacing_q} + 17'h00001;
	wire prls_lanes_t marker_good = marker_strobe & ~marker_malformed;
	prls_lanes_t spacing_ok;
	prls_lanes_t rep_full;

	////////////////////////////////////////////////////////////////////
	// per lane marker tracking
	for (genvar l = 0; l < `PRLS_LANES; l++) begin : g_lane
		// a lane with no reference marker yet cannot judge spacing
		assign spacing_ok[l] = ~seen_q[l] || (cnt_q[l] == spacing_target);
		wire mark_err = marker_strobe[l] &
			(marker_malformed[l] | ~spacing_ok[l]);
		assign rep_full[l] = (rep_cnt_q[l] == `PRLS_REP_LIMIT);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				cnt_q[l] <= '0;
			else if (marker_strobe[l])
				cnt_q[l] <= 17'h00001;
			else if (rx_word_valid)
				cnt_q[l] <= count_step(cnt_q[l]);
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				interval_q[l] <= 1'b0;
			else if (marker_strobe[l])
				interval_q[l] <= ~spacing_ok[l];
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				rep_cnt_q[l] <= '0;
			else if (marker_strobe[l] && !mark_err)
				rep_cnt_q[l] <= '0;
			else if (mark_err && !rep_full[l])
				rep_cnt_q[l] <= rep_cnt_q[l] + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// lane sync state
	wire prls_lanes_t seen_d = (seen_q | marker_good) & lane_lock_in;
	// loss by header errors holds until a marker is seen again; clearing
	// on seen_d keeps sync and loss complementary in every cycle once run_q is set
	wire prls_lanes_t lost_d = (lost_q | (lock_prev_q & ~lane_lock_in)) &
		~seen_d;
	wire align_lost_d = (align_lost_q | (align_prev_q & ~deskew_done_in)) &
		~deskew_done_in;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= '0;
			lost_q <= '0;
			lock_prev_q <= '0;
			align_prev_q <= 1'b0;
			align_lost_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			seen_q <= seen_d;
			lost_q <= lost_d;
			lock_prev_q <= lane_lock_in;
			align_prev_q <= deskew_done_in;
			align_lost_q <= align_lost_d;
			run_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered status outputs, all zero under reset
	// registered zeroed status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fe_q <= '0;
			fev_q <= '0;
			lock_q <= '0;
			wsync_q <= '0;
			loss_q <= '0;
			repeat_q <= '0;
			mkerr_q <= '0;
			aligned_q <= 1'b0;
			status_q <= 1'b0;
			lf_q <= 1'b0;
			aerr_q <= 1'b0;
		end else begin
			fe_q <= framing_err_in;
			fev_q <= framing_err_valid_in;
			lock_q <= lane_lock_in;
			wsync_q <= seen_d;
			loss_q <= ~seen_d | lost_d;
			repeat_q <= rep_full;
			mkerr_q <= marker_strobe & marker_malformed;
			aligned_q <= deskew_done_in;
			status_q <= deskew_done_in & ~high_error_rate_state;
			lf_q <= internal_fault_in | ~deskew_done_in | received_local_fault;
			aerr_q <= align_fault_in | align_lost_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb slave: one wait-free answer, registered read data
	wire setup_ph = psel & ~penable & ~pready_q;
	wire acc_done = psel & penable & pready_q;
	wire wr_en = acc_done & pwrite;
	wire hit_spacing = (paddr == `PRLS_OFS_SPACING);
	wire hit_status = (paddr == `PRLS_OFS_STATUS);
	wire hit_lock_lo = (paddr == `PRLS_OFS_LOCK_LO);
	wire hit_lock_hi = (paddr == `PRLS_OFS_LOCK_HI);
	wire hit_wsync = (paddr == `PRLS_OFS_WSYNC);
	wire hit_int_stat = (paddr == `PRLS_OFS_INT_STAT);
	wire hit_int_mask = (paddr == `PRLS_OFS_INT_MASK);
	wire hit_any = hit_spacing | hit_status | hit_lock_lo | hit_lock_hi |
		hit_wsync | hit_int_stat | hit_int_mask;
	wire [31:0] rd_mux =
		hit_spacing ? {16'h0000, spacing_q} :
		hit_status ? {28'h0000000, aerr_q, lf_q, status_q, aligned_q} :
		hit_lock_lo ? {24'h000000, lock_q[7:0]} :
		hit_lock_hi ? {20'h00000, lock_q[19:8]} :
		hit_wsync ? {12'h000, wsync_q} :
		hit_int_stat ? {27'h0000000, int_stat_q} :
		hit_int_mask ? {27'h0000000, int_mask_q} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= setup_ph;
			pslverr_q <= setup_ph & ~hit_any;
			prdata_q <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spacing_q <= `PRLS_RST_SPACING;
			int_mask_q <= `PRLS_RST_INT_MASK;
		end else if (wr_en) begin
			if (hit_spacing)
				spacing_q <= pwdata[15:0];
			if (hit_int_mask)
				int_mask_q <= pwdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky events; a new event wins over a write-one clear
	prls_events_t ev;
	assign ev[`PRLS_EV_MARKER_WORD] = |(marker_strobe & marker_malformed);
	assign ev[`PRLS_EV_INTERVAL] = |(marker_strobe & ~spacing_ok);
	assign ev[`PRLS_EV_REPEAT] = |(rep_full & ~repeat_q);
	assign ev[`PRLS_EV_SYNC_LOSS] = |(lock_prev_q & ~lane_lock_in);
	assign ev[`PRLS_EV_ALIGN] = align_fault_in | (align_prev_q & ~deskew_done_in);
	wire prls_events_t clr = (wr_en && hit_int_stat) ? pwdata[4:0] : 5'h00;
	wire prls_events_t int_stat_d = (int_stat_q & ~clr) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			int_stat_q <= int_stat_d;
			irq_q <= |(int_stat_d & int_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign framing_err = fe_q;
	assign framing_err_valid = fev_q;
	assign lane_block_lock = lock_q;
	assign lane_word_sync = wsync_q;
	assign lane_word_sync_loss = loss_q;
	assign marker_interval_error = interval_q;
	assign marker_repeat_error = repeat_q;
	assign marker_word_error = mkerr_q;
	assign lanes_aligned = aligned_q;
	assign coding_status = status_q;
	assign local_fault = lf_q;
	assign aligned_error = aerr_q;

	////////////////////////////////////////////////////////////////////
	AST_FE_VALID: assert property (run_q |->
		framing_err_valid == $past(framing_err_valid_in))
		else $error("framing qualifier does not follow lane");
	AST_LOCAL_FAULT: assert property (run_q &&
		$past(received_local_fault) |-> local_fault)
		else $error("received fault not on local fault");
	AST_WSYNC: assert property (run_q |->
		(lane_word_sync & ~$past(lane_lock_in)) == 20'h00000)
		else $error("word sync without lock");
	AST_SYNC_LOSS: assert property (run_q |->
		(lane_word_sync_loss | lane_word_sync) == 20'hfffff)
		else $error("lane neither synced nor flagged lost");
	AST_MARKER_PULSE: assert property (run_q |->
		marker_word_error == $past(marker_strobe & marker_malformed))
		else $error("marker word error pulse wrong");
	AST_UNALIGNED_FAULT: assert property (run_q &&
		!lanes_aligned |-> local_fault)
		else $error("unaligned without local fault");
	AST_CODING: assert property (coding_status |->
		lanes_aligned && !$past(high_error_rate_state))
		else $error("coding status while unaligned or high rate");
	AST_REPEAT: assert property (run_q |->
		marker_repeat_error == $past(rep_full))
		else $error("repeat error does not follow four errors");
	AST_ALIGN_LOST: assert property (run_q &&
		$fell(deskew_done_in) |=> aligned_error)
		else $error("alignment loss not flagged");
endmodule // prls_pcs_rx_lane_status
`default_nettype wire

// ### prls_defines.svh
// register offsets, reset values and counts of the lane status block
`ifndef PRLS_DEFINES_SVH
`define PRLS_DEFINES_SVH
`define PRLS_LANES 20
`define PRLS_CNT_W 17
`define PRLS_REP_LIMIT 3'h4
`define PRLS_OFS_SPACING 12'h000
`define PRLS_OFS_STATUS 12'h004
`define PRLS_OFS_LOCK_LO 12'h008
`define PRLS_OFS_LOCK_HI 12'h00c
`define PRLS_OFS_WSYNC 12'h010
`define PRLS_OFS_INT_STAT 12'h014
`define PRLS_OFS_INT_MASK 12'h018
`define PRLS_RST_SPACING 16'h3fff
`define PRLS_RST_INT_MASK 5'h00
`define PRLS_EV_MARKER_WORD 0
`define PRLS_EV_INTERVAL 1
`define PRLS_EV_REPEAT 2
`define PRLS_EV_SYNC_LOSS 3
`define PRLS_EV_ALIGN 4
`endif

// ### prls_pkg.sv
// types shared by the lane status block
package prls_pkg;
	typedef logic [19:0] prls_lanes_t;
	typedef logic [4:0] prls_events_t;
	typedef logic [16:0] prls_count_t;
endpackage

// ### prls_fabric_mon.sv
// fabric-side monitor that keeps framing values only when qualified
`timescale 1ns/100ps
`default_nettype none
module prls_fabric_mon
	import prls_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// status from the block
	input wire logic [39:0] framing_err,
	input wire prls_lanes_t framing_err_valid,
	// last qualified value per lane
	output logic [39:0] kept_err
);
////////////////////////////////////////////////////////////
	// qualified capture only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			kept_err <= 40'h0;
		else
			for (int n = 0; n < 20; n++)
				if (framing_err_valid[n])
					kept_err[2*n+:2] <= framing_err[2*n+:2];
	end
endmodule // prls_fabric_mon
`default_nettype wire

// ### testbench.sv
// self-checking bench for the lane status block
`timescale 1ns/100ps
`default_nettype none
`include "prls_defines.svh"
module testbench
	import prls_pkg::*;
;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic rx_word_valid, deskew_done_in, align_fault_in, high_error_rate_state;
logic internal_fault_in, received_local_fault;
logic lanes_aligned, coding_status, local_fault, aligned_error;
prls_lanes_t lane_lock_in, marker_strobe, marker_malformed;
prls_lanes_t framing_err_valid_in, framing_err_valid, lane_block_lock;
prls_lanes_t lane_word_sync, lane_word_sync_loss, marker_interval_error;
prls_lanes_t marker_repeat_error, marker_word_error;
logic [39:0] framing_err_in, framing_err, kept_err;
int mismatches, cmp_count;
// inputs {deskew, high rate, internal, received, align fault}
logic [4:0] gin [6] = '{5'h10, 5'h1c, 5'h12, 5'h00, 5'h11, 5'h10};
// outputs {aligned error, local fault, coding, aligned}
logic [3:0] gout [6] = '{4'h3, 4'h5, 4'h7, 4'hc, 4'hb, 4'h3};
////////////////////////////////////////////////////////////
prls_pcs_rx_lane_status uut (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .rx_word_valid,
	.lane_lock_in, .marker_strobe, .marker_malformed, .framing_err_in,
	.framing_err_valid_in, .deskew_done_in, .align_fault_in,
	.high_error_rate_state, .internal_fault_in, .received_local_fault,
	.framing_err, .framing_err_valid, .lane_block_lock, .lane_word_sync,
	.lane_word_sync_loss, .marker_interval_error, .marker_repeat_error,
	.marker_word_error, .lanes_aligned, .coding_status, .local_fault,
	.aligned_error);
prls_fabric_mon mon (.pclk, .presetn, .framing_err, .framing_err_valid,
	.kept_err);
////////////////////////////////////////////////////////////
initial begin
	pclk = 1'b0;
	forever #5 pclk = ~pclk;
end
task print_verdict;
	if (mismatches == 0 && cmp_count > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task chk(input logic [39:0] got, input logic [39:0] exp);
	cmp_count++;
	if (got !== exp) begin
		mismatches++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	int n;
	@(posedge pclk);
	{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
	@(posedge pclk);
	penable <= 1'b1;
	n = 0;
	@(posedge pclk);
	while (pready !== 1'b1) begin
		n++;
		if (n > 16) begin
			$display("Error at %0t: no bus answer", $time);
			mismatches++;
			print_verdict;
		end
		@(posedge pclk);
	end
	rd = prdata;
	er = pslverr;
	{psel, penable} <= 2'b00;
endtask
task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
	apb(1'b0, a, 32'h0);
	chk(rd, exp);
	chk(er, e);
endtask
// marker every fourth cycle unless gap adds idle cycles
task mark(input int ln, input logic bad, input int gap);
	repeat (gap) @(posedge pclk);
	@(posedge pclk);
	marker_strobe <= 20'h1 << ln;
	marker_malformed <= bad ? 20'h1 << ln : 20'h0;
	@(posedge pclk);
	{marker_strobe, marker_malformed} <= 40'h0;
	@(posedge pclk);
	chk(marker_word_error[ln], bad);
	@(posedge pclk);
	chk(marker_word_error[ln], 1'b0);
endtask
initial begin
	repeat (20000) @(posedge pclk);
	mismatches++;
	print_verdict;
end
initial begin
	mismatches = 0;
	cmp_count = 0;
	{presetn, psel, penable, pwrite, paddr, pwdata, rx_word_valid} = '0;
	{lane_lock_in, marker_strobe, marker_malformed, framing_err_in} = '0;
	{framing_err_valid_in, deskew_done_in, align_fault_in} = '0;
	{high_error_rate_state, internal_fault_in, received_local_fault} = '0;
	repeat (4) @(posedge pclk);
	chk({lanes_aligned, local_fault, lane_word_sync_loss}, 0);
	presetn <= 1'b1;
	rx_word_valid <= 1'b1;
	lane_lock_in <= 20'h5a3c8;
	framing_err_in <= 40'h9a5c3e1f27;
	framing_err_valid_in <= 20'hfc000;
	repeat (3) @(posedge pclk);
	chk(framing_err, 40'h9a5c3e1f27);
	chk(framing_err_valid, 20'hfc000);
	chk(kept_err, 40'h9a50000000);
	chk(lane_block_lock, 20'h5a3c8);
	chk(lane_word_sync_loss, 20'hfffff);
	rdchk(`PRLS_OFS_LOCK_LO, 32'hc8, 1'b0);
	rdchk(`PRLS_OFS_LOCK_HI, 32'h5a3, 1'b0);
	rdchk(`PRLS_OFS_SPACING, 32'h3fff, 1'b0);
	rdchk(`PRLS_OFS_INT_MASK, 32'h0, 1'b0);
	rdchk(12'hffc, 32'h0, 1'b1);
	apb(1'b1, `PRLS_OFS_SPACING, 32'h3);
	rdchk(`PRLS_OFS_SPACING, 32'h3, 1'b0);
	for (int i = 0; i < 6; i++) begin
		{deskew_done_in, high_error_rate_state, internal_fault_in,
			received_local_fault, align_fault_in} <= gin[i];
		repeat (2) @(posedge pclk);
		chk({aligned_error, local_fault, coding_status, lanes_aligned},
			gout[i]);
		rdchk(`PRLS_OFS_STATUS, gout[i], 1'b0);
	end
	mark(3, 1'b0, 0);
	mark(3, 1'b0, 0);
	chk(marker_interval_error[3], 1'b0);
	mark(3, 1'b0, 1);
	chk(marker_interval_error[3], 1'b1);
	mark(3, 1'b0, 0);
	chk(marker_interval_error[3], 1'b0);
	for (int i = 0; i < 4; i++) begin
		mark(3, 1'b1, 0);
		chk(marker_repeat_error[3], i == 3);
	end
	mark(3, 1'b0, 0);
	chk(marker_repeat_error[3], 1'b0);
	chk(lane_word_sync, 20'h8);
	chk(lane_word_sync_loss, 20'hffff7);
	rdchk(`PRLS_OFS_WSYNC, 32'h8, 1'b0);
	lane_lock_in <= 20'h0;
	repeat (2) @(posedge pclk);
	chk(lane_word_sync, 20'h0);
	chk(lane_word_sync_loss, 20'hfffff);
	rdchk(`PRLS_OFS_INT_STAT, 32'h1f, 1'b0);
	chk(irq, 1'b0);
	apb(1'b1, `PRLS_OFS_INT_MASK, 32'h1f);
	repeat (2) @(posedge pclk);
	chk(irq, 1'b1);
	apb(1'b1, `PRLS_OFS_INT_STAT, 32'h1b);
	rdchk(`PRLS_OFS_INT_STAT, 32'h4, 1'b0);
	chk(irq, 1'b1);
	apb(1'b1, `PRLS_OFS_INT_MASK, 32'h1b);
	repeat (2) @(posedge pclk);
	chk(irq, 1'b0);
	apb(1'b1, `PRLS_OFS_INT_STAT, 32'h4);
	rdchk(`PRLS_OFS_INT_STAT, 32'h0, 1'b0);
	print_verdict;
end
endmodule // testbench
`default_nettype wire
